//--- bench/config_reg_irq_gpo_control_bench.sv
// Self-checking bench for the configuration register block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
    num_checks++; \
    if ((got) !== (ex)) begin \
        n_errors++; \
        $display("[FAIL] %s exp %h got %h", nm, ex, got); \
    end \
end
module config_reg_irq_gpo_control_bench;
    logic ref_clk, rst_b, blink_pin, data_change, blink_phase;
    logic input_sample_req, pin_out, pin_oe;
    logic [7:0] master_intensity;
    logic [63:0] per_port_intensity, port_intensity;
    logic [3:0] gpo_intensity;
    cfg_pkg::reg_req_t reg_req;
    cfg_pkg::reg_rsp_t reg_rsp;
    int n_errors = 0;
    int num_checks = 0;
    config_reg_irq_gpo_control config_reg_irq_gpo_control_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_req(reg_req),
        .reg_rsp(reg_rsp), .blink_pin(blink_pin),
        .data_change(data_change), .master_intensity(master_intensity),
        .per_port_intensity(per_port_intensity),
        .port_intensity(port_intensity), .gpo_intensity(gpo_intensity),
        .blink_phase(blink_phase), .input_sample_req(input_sample_req),
        .irq_or_gpo_pin_out(pin_out), .irq_or_gpo_pin_oe(pin_oe));
    reg_master_model reg_master_model_inst (
        .ref_clk(ref_clk), .reg_req(reg_req), .reg_rsp(reg_rsp));
    ////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    task automatic close_out();
        if (n_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    task automatic rdchk(input logic [7:0] ex);
        logic [7:0] q;
        bit ok;
        reg_master_model_inst.rd(8'h0F, q, ok);
        if (!ok) begin
            n_errors++;
            close_out();
        end
        `CHK("rdata", ex, q)
    endtask : rdchk
    task automatic t_reset();
        rdchk(8'h0C);
        `CHK("oe", 1'b0, pin_oe)
        `CHK("pin_out", 1'b0, pin_out)
    endtask : t_reset
    task automatic t_irq();
        reg_master_model_inst.wr(8'h0F, 8'hFA);
        `CHK("sample", 1'b1, input_sample_req)
        rdchk(8'h3A);
        data_change = 1'b1;
        blink_pin = 1'b1;
        cyc(1);
        `CHK("oe", 1'b0, pin_oe)
        cyc(1);
        `CHK("oe", 1'b1, pin_oe)
        rdchk(8'hFA);
        data_change = 1'b0;
        cyc(3);
        `CHK("oe", 1'b0, pin_oe)
        rdchk(8'h7A);
    endtask : t_irq
    // Rows: wdata, blink pin, expected phase, expected pin enable
    task automatic t_pins();
        logic [10:0] rows [9] = '{
            {8'h00, 3'b001}, {8'h30, 3'b100}, {8'h22, 3'b101},
            {8'h11, 3'b000}, {8'h11, 3'b111}, {8'h13, 3'b011},
            {8'h13, 3'b100}, {8'h21, 3'b001}, {8'h23, 3'b010}};
        foreach (rows[i]) begin
            blink_pin = rows[i][2];
            reg_master_model_inst.wr(8'h0F, rows[i][10:3]);
            cyc(6);
            `CHK("phase", rows[i][1], blink_phase)
            `CHK("oe", rows[i][0], pin_oe)
            rdchk({1'b0, rows[i][2], rows[i][8:3]});
        end
    endtask : t_pins
    task automatic t_intensity();
        reg_master_model_inst.wr(8'h0F, 8'h04);
        cyc(3);
        `CHK("port", {16{4'h7}}, port_intensity)
        `CHK("gpo", 4'h7, gpo_intensity)
        master_intensity = 8'h5C;
        reg_master_model_inst.wr(8'h0F, 8'h00);
        cyc(3);
        `CHK("port", per_port_intensity, port_intensity)
        `CHK("gpo", 4'hC, gpo_intensity)
    endtask : t_intensity
    task automatic t_mid_reset();
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
        cyc(1);
        `CHK("oe", 1'b0, pin_oe)
        `CHK("port", {16{4'hC}}, port_intensity)
        rdchk(8'h0C);
    endtask : t_mid_reset
    task automatic t_unmapped();
        logic [7:0] q;
        bit ok;
        reg_master_model_inst.wr(8'h0E, 8'h3F);
        `CHK("sample", 1'b0, input_sample_req)
        reg_master_model_inst.rd(8'h0E, q, ok);
        `CHK("answer", 1'b0, ok)
        rdchk(8'h00);
    endtask : t_unmapped
    ////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        rst_b = 1'b0;
        blink_pin = 1'b0;
        data_change = 1'b0;
        master_intensity = 8'hA7;
        per_port_intensity = 64'h0123456789ABCDEF;
        cyc(8);
        rst_b = 1'b1;
        cyc(1);
        t_reset();
        t_irq();
        t_pins();
        t_intensity();
        t_unmapped();
        t_mid_reset();
        close_out();
    end
endmodule : config_reg_irq_gpo_control_bench

//--- bench/reg_master_model.sv
// Register master model driving the configuration register port
`timescale 1ns/10ps
module reg_master_model (
    input wire logic ref_clk,
    output cfg_pkg::reg_req_t reg_req,
    input cfg_pkg::reg_rsp_t reg_rsp
);
    initial begin
        reg_req = '0;
    end
    // Idle fields carry inverted values so stale data is never mistaken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk) reg_req <= '{1'b1, 1'b0, a, d};
        @(negedge ref_clk) reg_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] q,
                      output bit ok);
        ok = 1'b0;
        q = 8'h00;
        @(negedge ref_clk) reg_req <= '{1'b0, 1'b1, a, 8'h5A};
        for (int i = 0; i < 3 && !ok; i++) begin
            @(negedge ref_clk) reg_req <= '{1'b0, 1'b0, ~a, 8'hA5};
            if (reg_rsp.valid === 1'b1) begin
                q = reg_rsp.rdata;
                ok = 1'b1;
            end
        end
    endtask : rd
endmodule : reg_master_model

//--- rtl/blink_pin_sync.sv
// Two-stage synchroniser for the blink input pin
`timescale 1ns/10ps
module blink_pin_sync (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic blink_pin,
    output logic blink_level
);
    cfg_pkg::sync_state_t state;
    cfg_pkg::sync_state_t next_state;

    always_comb begin
        next_state.stage1 = blink_pin;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign blink_level = state.stage2;
endmodule : blink_pin_sync

//--- rtl/cfg_map.svh
// Offsets, bit positions and reset values of the configuration register
`ifndef CFG_MAP_SVH
`define CFG_MAP_SVH
`define CFG_REG_ADDR 8'h0F
`define CFG_RESET_BITS 6'h0C
`define CFG_BIT_IRQ_STATUS 7
`define CFG_BIT_BLINK_STATUS 6
`define CFG_CTRL_MSB 5
`define MASTER_NIBBLE_MSB 3
`define PORT_COUNT 16
`endif

//--- rtl/cfg_pkg.sv
// Types shared by the configuration register block
package cfg_pkg;
    // Stored control bits, D5 down to D0
    typedef struct packed {
        logic phase1_pin_level;
        logic phase0_pin_level;
        logic irq_enable;
        logic global_intensity;
        logic blink_flip;
        logic blink_enable;
    } cfg_bits_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
    } reg_rsp_t;

    typedef struct packed {
        logic stage1;
        logic stage2;
    } sync_state_t;

    typedef struct packed {
        cfg_bits_t cfg;
        logic irq_status;
        logic blink_phase;
        logic pin_oe;
        logic sample_req;
        logic [3:0] gpo_intensity;
        logic [63:0] port_intensity;
        reg_rsp_t rsp;
    } ctl_state_t;
endpackage : cfg_pkg

//--- rtl/config_reg_irq_gpo_control.sv
// Device configuration register, blink phase and interrupt/GPO pin control
`timescale 1ns/10ps
`include "cfg_map.svh"

// Functional notes
// - Register 0x0F holds blink enable in D0 and the blink flip in D1.
// - With D2 clear each port uses its own intensity, the pin the master.
// - With D2 set every port uses the master intensity low nibble.
// - With D3 clear the combined pin is a GPO driven from D4 and D5.
// - With D3 set the combined pin follows the data change detection.
// - Interrupt and blink off: D4 of 0 pulls the pin low, 1 releases it.
// - Interrupt off, blink on, phase 0: D4 sets the pin level.
// - Interrupt off, blink on, phase 1: D5 sets the pin level.
// - A read returns D5..D0 stored, interrupt status D7, blink pin D6.
// - With blink on the phase is the flip bit xor the blink pin level.
// - With blink off the flip bit is ignored and phase 0 is used.
// - Interrupt on: status 1 and pin low while a change is detected.
module config_reg_irq_gpo_control (
    input wire logic ref_clk,
    input wire logic rst_b,
    input cfg_pkg::reg_req_t reg_req,
    output cfg_pkg::reg_rsp_t reg_rsp,
    input wire logic blink_pin,
    input wire logic data_change,
    input wire logic [7:0] master_intensity,
    input wire logic [63:0] per_port_intensity,
    output logic [63:0] port_intensity,
    output logic [3:0] gpo_intensity,
    output logic blink_phase,
    output logic input_sample_req,
    output logic irq_or_gpo_pin_out,
    output logic irq_or_gpo_pin_oe
);
    ////////////////////////////////////////////////////////////////////////
    cfg_pkg::ctl_state_t state;
    cfg_pkg::ctl_state_t next_state;
    logic blink_level;
    logic cfg_hit_wr;
    logic cfg_hit_rd;

    blink_pin_sync blink_pin_sync_inst (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .blink_pin(blink_pin),
        .blink_level(blink_level)
    );

    // Level the GPO asks for; 1 releases the open-drain pin
    function automatic logic gpo_level(input cfg_pkg::cfg_bits_t c,
                                       input logic phase);
        if (c.blink_enable && phase) begin
            gpo_level = c.phase1_pin_level;
        end else begin
            gpo_level = c.phase0_pin_level;
        end
    endfunction : gpo_level

    function automatic logic is_cfg(input logic [7:0] addr);
        is_cfg = (addr == `CFG_REG_ADDR);
    endfunction : is_cfg

    assign cfg_hit_wr = reg_req.wr && is_cfg(reg_req.addr);
    assign cfg_hit_rd = reg_req.rd && is_cfg(reg_req.addr);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        next_state.rsp.valid = 1'b0;
        next_state.sample_req = 1'b0;
        if (cfg_hit_wr) begin
            // Status positions D7 and D6 are dropped here
            next_state.cfg = cfg_pkg::cfg_bits_t'(
                reg_req.wdata[`CFG_CTRL_MSB:0]);
            // Writing the register resamples the port inputs
            next_state.sample_req = 1'b1;
        end
        if (cfg_hit_rd) begin
            next_state.rsp.valid = 1'b1;
            next_state.rsp.rdata = {state.irq_status, blink_level,
                                    state.cfg};
        end
        next_state.irq_status = data_change;
        next_state.blink_phase = state.cfg.blink_enable
            && (state.cfg.blink_flip ^ blink_level);
        if (state.cfg.irq_enable) begin
            next_state.pin_oe = state.irq_status;
        end else begin
            next_state.pin_oe =
                !gpo_level(state.cfg, state.blink_phase);
        end
        next_state.gpo_intensity =
            master_intensity[`MASTER_NIBBLE_MSB:0];
        if (state.cfg.global_intensity) begin
            next_state.port_intensity = {`PORT_COUNT{
                master_intensity[`MASTER_NIBBLE_MSB:0]}};
        end else begin
            next_state.port_intensity = per_port_intensity;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state <= '0;
            state.cfg <= cfg_pkg::cfg_bits_t'(`CFG_RESET_BITS);
            state.pin_oe <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rsp = state.rsp;
    assign port_intensity = state.port_intensity;
    assign gpo_intensity = state.gpo_intensity;
    assign blink_phase = state.blink_phase;
    assign input_sample_req = state.sample_req;
    assign irq_or_gpo_pin_out = 1'b0;
    assign irq_or_gpo_pin_oe = state.pin_oe;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    sequence cfg_write_s;
        reg_req.wr && reg_req.addr == `CFG_REG_ADDR;
    endsequence

    sequence cfg_read_s;
        reg_req.rd && reg_req.addr == `CFG_REG_ADDR;
    endsequence

    sequence gpo_blink_s(logic ph);
        !state.cfg.irq_enable && state.cfg.blink_enable
            && state.blink_phase == ph;
    endsequence

    AST_CFG_WRITE_STORES:
    assert property (cfg_write_s |=> state.cfg == $past(reg_req.wdata[5:0])
                     && input_sample_req)
        else $error("config write not stored");

    AST_STATUS_BITS_IGNORED:
    assert property (cfg_write_s |=> state.irq_status == $past(data_change))
        else $error("status changed by a write");

    AST_READ_LAYOUT:
    assert property (cfg_read_s |=> reg_rsp.valid && reg_rsp.rdata ==
                     {$past(state.irq_status), $past(blink_level),
                      $past(state.cfg)})
        else $error("config readback wrong");

    AST_PHASE_XOR:
    assert property (state.cfg.blink_enable |=> blink_phase ==
                     $past(state.cfg.blink_flip ^ blink_level))
        else $error("blink phase not flip xor pin");

    AST_PHASE_OFF:
    assert property (!state.cfg.blink_enable |=> !blink_phase)
        else $error("phase 1 used while blink off");

    AST_GLOBAL_INTENSITY:
    assert property (state.cfg.global_intensity |=> port_intensity ==
                     {16{$past(master_intensity[3:0])}})
        else $error("global intensity not applied");

    AST_PORT_INTENSITY:
    assert property (!state.cfg.global_intensity |=> port_intensity ==
                     $past(per_port_intensity)
                     && gpo_intensity == $past(master_intensity[3:0]))
        else $error("per-port intensity not applied");

    AST_IRQ_PIN:
    assert property (state.cfg.irq_enable && data_change ##1
                     state.cfg.irq_enable |=> irq_or_gpo_pin_oe
                     && !irq_or_gpo_pin_out)
        else $error("pin not pulled low on change");

    AST_IRQ_RELEASE:
    assert property (state.cfg.irq_enable && !state.irq_status
                     |=> !irq_or_gpo_pin_oe)
        else $error("pin not released without change");

    AST_GPO_STATIC:
    assert property (!state.cfg.irq_enable && !state.cfg.blink_enable
                     |=> irq_or_gpo_pin_oe ==
                     !$past(state.cfg.phase0_pin_level))
        else $error("static gpo level wrong");

    AST_GPO_PHASE0:
    assert property (gpo_blink_s(1'b0) |=> irq_or_gpo_pin_oe ==
                     !$past(state.cfg.phase0_pin_level))
        else $error("phase 0 gpo level wrong");

    AST_GPO_PHASE1:
    assert property (gpo_blink_s(1'b1) |=> irq_or_gpo_pin_oe ==
                     !$past(state.cfg.phase1_pin_level))
        else $error("phase 1 gpo level wrong");

    AST_GPO_NOT_IRQ:
    assert property (!state.cfg.irq_enable && !state.cfg.blink_enable
                     && state.cfg.phase0_pin_level [*2]
                     |=> !irq_or_gpo_pin_oe)
        else $error("released gpo driven low");

    AST_CFG_HOLD:
    assert property (!(reg_req.wr && reg_req.addr == `CFG_REG_ADDR)
                     |=> $stable(state.cfg))
        else $error("config changed without a write");

    AST_SAMPLE_ONLY_ON_WRITE:
    assert property (!(reg_req.wr && reg_req.addr == `CFG_REG_ADDR)
                     |=> !input_sample_req)
        else $error("input resample without a config write");

    AST_NO_ANSWER:
    assert property (!(reg_req.rd && reg_req.addr == `CFG_REG_ADDR)
                     |=> !reg_rsp.valid)
        else $error("read answered without a config read");

    AST_GPO_INTENSITY:
    assert property (state.cfg.global_intensity |=> gpo_intensity ==
                     $past(master_intensity[3:0]))
        else $error("pin intensity not from master");
endmodule : config_reg_irq_gpo_control
